// ---- hdl/bmdma_regs.vh ----
// bmdma_regs.vh: constants for the buffer-manager dma port.
// this file assumes it is included by the design files and holds definitions only.
`ifndef BMDMA_REGS_VH
`define BMDMA_REGS_VH

// ==========================================================
// configuration page word addresses
`define BMDMA_CFG_ADDR 4'h0
`define BMDMA_CNT_ADDR 4'h1
`define BMDMA_STAT_ADDR 4'h2

// ==========================================================
// configuration word fields
`define BMDMA_CFG_WIDE 0
`define BMDMA_CFG_POL_REQ 1
`define BMDMA_CFG_POL_ACK 2
`define BMDMA_CFG_POL_RD 3
`define BMDMA_CFG_POL_WR 4
`define BMDMA_CFG_MASTER 5
`define BMDMA_CFG_BURST_LO 6
`define BMDMA_CFG_BURST_HI 7
`define BMDMA_CFG_MODE_LO 8
`define BMDMA_CFG_MODE_HI 9
`define BMDMA_CFG_INBOUND 10
`define BMDMA_CFG_VALID 15
`define BMDMA_CFG_RESET 16'h0000

// ==========================================================
// slave burst settings
`define BMDMA_BURST_HOLD 2'h0
`define BMDMA_BURST_SINGLE 2'h1
`define BMDMA_BURST_TWO 2'h2
`define BMDMA_BURST_FOUR 2'h3
`define BMDMA_UNITS_ONE 8'h01
`define BMDMA_UNITS_TWO 8'h02
`define BMDMA_UNITS_FOUR 8'h04

// ==========================================================
// strobe modes
`define BMDMA_MODE_STROBES 2'h0
`define BMDMA_MODE_ACK_OUT 2'h1
`define BMDMA_MODE_ACK_BOTH 2'h2

// ==========================================================
// master timing defaults, in clock cycles
`define BMDMA_STB_CYC 2
`define BMDMA_GAP_CYC 1

`endif

// ---- hdl/bmdma_edge.v ----
// bmdma_edge.v: normalises one strobe pin to active-high and finds its edges.
// assumes the pin is already synchronous to the system clock.
`timescale 1ns/10ps

module bmdma_edge (
    input wire clk_i,
    input wire rst_i,
    input wire mrst_n_i,
    input wire pin_i,
    input wire act_high_i,
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);

    // ==========================================================
    // level and edge detection
    reg prev_reg; // level seen in the previous cycle

    assign level_o = act_high_i ? pin_i : ~pin_i;
    assign rise_o = level_o & ~prev_reg;
    assign fall_o = ~level_o & prev_reg;

    // remember the last level
    always @(posedge clk_i or negedge mrst_n_i) begin
        if (!mrst_n_i) begin
            prev_reg <= 1'b0;
        end else if (rst_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level_o;
        end
    end

endmodule // bmdma_edge

// ---- hdl/bmdma_port.v ----
// bmdma_port.v: dma port between the internal fifo and an external buffer manager.
// assumes synchronous pins, an external fifo with push/pop and level counts,
// and a configuration page written over the plain register port.
// Operation
// - data bus 8 or 16 bits wide
// - each strobe line has own polarity
// - master or slave role, slave burst selectable
// - slave: device requests, manager acknowledges
// - burst A: hold request until done or empty
// - burst B: request toggles per unit
// - never request without fifo room or data
// - burst C: wait two units, request two
// - burst D: wait four units, request four
// - repeat bursts until transfer complete
// - mode 0: write strobe in, read strobe out
// - mode 1: write strobe in, ack out
// - mode 2: ack latches in and drives out
// - master: peripheral requests, device acknowledges
// - strobes driven by manager or device by role
// - strobe modes in master, bursts ignored
// - master pacing by strobe spacing
// - master acts as ata host
// - configuration comes from written page
// - active-low master reset is asynchronous
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "bmdma_regs.vh"

module bmdma_port #(
    parameter CNT_W = 16,
    parameter LVL_W = 8,
    parameter STB_CYC = `BMDMA_STB_CYC,
    parameter GAP_CYC = `BMDMA_GAP_CYC
) (
    input wire SYS_CLK_I,
    input wire RST_I,
    input wire MRST_N_I,
    input wire [3:0] ADDR_I,
    input wire [15:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [15:0] RDATA_O,
    output wire DMA_REQ_O,
    input wire DMA_ACK_I,
    input wire DMA_RD_I,
    output wire DMA_RD_O,
    output wire DMA_RD_OE_O,
    input wire DMA_WR_I,
    output wire DMA_WR_O,
    output wire DMA_WR_OE_O,
    input wire [15:0] DMA_DATA_I,
    output wire [15:0] DMA_DATA_O,
    output wire [15:0] DMA_DATA_OE_O,
    input wire [LVL_W-1:0] FIFO_DATA_CNT_I,
    input wire [LVL_W-1:0] FIFO_ROOM_CNT_I,
    input wire [15:0] FIFO_RDATA_I,
    output reg FIFO_POP_O,
    output reg FIFO_PUSH_O,
    output reg [15:0] FIFO_WDATA_O
);

    // ==========================================================
    // states
    localparam S_IDLE = 1'b0;
    localparam S_REQ = 1'b1;
    localparam M_IDLE = 2'b00;
    localparam M_ACT = 2'b01;
    localparam M_STB = 2'b10;
    localparam M_GAP = 2'b11;
    // cut to timer width
    localparam [31:0] STB_LAST_W = STB_CYC - 1;
    localparam [31:0] GAP_LAST_W = GAP_CYC - 1;
    localparam [7:0] STB_LAST = STB_LAST_W[7:0];
    localparam [7:0] GAP_LAST = GAP_LAST_W[7:0];

    // ==========================================================
    // configuration and state registers
    reg [15:0] cfg_reg; // configuration page word
    reg [CNT_W-1:0] rem_reg; // units left in the transfer
    reg [7:0] burst_reg; // units left in this slave burst
    reg sstate_reg; // slave request state
    reg [1:0] mstate_reg; // master sequencer state
    reg [7:0] tcnt_reg; // master strobe / gap timer
    reg [15:0] dout_reg; // outbound data held on the bus

    // configuration fields
    wire loaded = cfg_reg[`BMDMA_CFG_VALID];
    wire wide = cfg_reg[`BMDMA_CFG_WIDE];
    wire master = cfg_reg[`BMDMA_CFG_MASTER];
    wire inbound = cfg_reg[`BMDMA_CFG_INBOUND];
    wire [1:0] burst = cfg_reg[`BMDMA_CFG_BURST_HI:`BMDMA_CFG_BURST_LO];
    wire [1:0] mode = cfg_reg[`BMDMA_CFG_MODE_HI:`BMDMA_CFG_MODE_LO];
    wire slave_on = loaded & ~master;
    wire master_on = loaded & master;
    wire busy = rem_reg != {CNT_W{1'b0}};

    // room for inbound, data for outbound
    wire [LVL_W-1:0] avail = inbound ? FIFO_ROOM_CNT_I : FIFO_DATA_CNT_I;

    // ==========================================================
    // strobe pin conditioning: ack, read, write
    wire [2:0] pin_in = {DMA_WR_I, DMA_RD_I, DMA_ACK_I};
    wire [2:0] pol_in = {cfg_reg[`BMDMA_CFG_POL_WR], cfg_reg[`BMDMA_CFG_POL_RD],
                         cfg_reg[`BMDMA_CFG_POL_ACK]};
    wire [2:0] lvl;
    wire [2:0] rise;
    wire [2:0] fall;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
            bmdma_edge u_edge (
                .clk_i(SYS_CLK_I),
                .rst_i(RST_I),
                .mrst_n_i(MRST_N_I),
                .pin_i(pin_in[gi]),
                .act_high_i(pol_in[gi]),
                .level_o(lvl[gi]),
                .rise_o(rise[gi]),
                .fall_o(fall[gi])
            );
        end
    endgenerate

    // ==========================================================
    // slave data events
    // inbound latch strobe: write strobe in modes 0/1, ack in mode 2
    wire s_latch_rise = (mode == `BMDMA_MODE_ACK_BOTH) ? rise[0] : rise[2];
    // outbound gate: read strobe in mode 0, ack in modes 1/2
    wire s_gate_lvl = (mode == `BMDMA_MODE_STROBES) ? lvl[1] : lvl[0];
    wire s_gate_fall = (mode == `BMDMA_MODE_STROBES) ? fall[1] : fall[0];
    wire s_xfer = slave_on & busy & (inbound ? s_latch_rise : s_gate_fall);

    // ==========================================================
    // master data events
    wire dmarq = lvl[0]; // ack pin acts as peripheral request
    wire m_xfer = master_on & (mstate_reg == M_STB) & (tcnt_reg == 8'h00);
    wire xfer = s_xfer | m_xfer;
    // drive window, set below
    wire bus_drive;

    // ==========================================================
    // slave burst sizes
    reg [7:0] need; // units the fifo must hold before requesting
    always @* begin
        case (burst)
            `BMDMA_BURST_TWO: need = `BMDMA_UNITS_TWO;
            `BMDMA_BURST_FOUR: need = `BMDMA_UNITS_FOUR;
            default: need = `BMDMA_UNITS_ONE;
        endcase
    end
    // widen, then cut to 8 bits
    wire [LVL_W+7:0] avail_ext = {8'h00, avail};
    wire [7:0] avail8 = avail_ext[7:0];
    wire [CNT_W-1:0] one_cnt = {{(CNT_W - 1){1'b0}}, 1'b1};
    // last unit not yet in fifo level
    wire pend = FIFO_PUSH_O | FIFO_POP_O;
    wire [7:0] need_in = need + {7'h00, pend};
    wire room_ok = avail8 > {7'h00, pend};

    // ==========================================================
    // slave request sequencer
    always @(posedge SYS_CLK_I or negedge MRST_N_I) begin
        if (!MRST_N_I) begin
            sstate_reg <= S_IDLE;
            burst_reg <= 8'h00;
        end else if (RST_I) begin
            sstate_reg <= S_IDLE;
            burst_reg <= 8'h00;
        end else begin
            case (sstate_reg)
                S_IDLE: begin
                    // start a burst only with enough room or data
                    if (slave_on && busy && avail8 >= need_in) begin
                        sstate_reg <= S_REQ;
                        burst_reg <= need;
                    end
                end
                S_REQ: begin
                    if (!slave_on || !busy) begin
                        sstate_reg <= S_IDLE;
                    end else if (xfer) begin
                        burst_reg <= burst_reg - 8'h01;
                        if (rem_reg == one_cnt) begin
                            sstate_reg <= S_IDLE; // last unit moved
                        end else if (burst == `BMDMA_BURST_HOLD) begin
                            // hold while more room/data remains
                            if (avail8 <= `BMDMA_UNITS_ONE) begin
                                sstate_reg <= S_IDLE;
                            end
                        end else if (burst == `BMDMA_BURST_SINGLE) begin
                            sstate_reg <= S_IDLE;
                        end else if (burst_reg == `BMDMA_UNITS_ONE) begin
                            sstate_reg <= S_IDLE;
                        end
                    end else if (burst == `BMDMA_BURST_HOLD && avail8 == 8'h00) begin
                        sstate_reg <= S_IDLE; // fifo drained elsewhere
                    end
                end
                default: sstate_reg <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // master sequencer: acknowledge, strobe, recovery gap
    always @(posedge SYS_CLK_I or negedge MRST_N_I) begin
        if (!MRST_N_I) begin
            mstate_reg <= M_IDLE;
            tcnt_reg <= 8'h00;
        end else if (RST_I) begin
            mstate_reg <= M_IDLE;
            tcnt_reg <= 8'h00;
        end else begin
            case (mstate_reg)
                M_IDLE: begin
                    // burst begins when the peripheral requests
                    if (master_on && busy && dmarq && room_ok) begin
                        mstate_reg <= M_ACT;
                    end
                end
                M_ACT: begin
                    mstate_reg <= M_STB;
                    tcnt_reg <= STB_LAST;
                end
                M_STB: begin
                    if (!master_on) begin
                        mstate_reg <= M_IDLE;
                    end else if (tcnt_reg == 8'h00) begin
                        mstate_reg <= M_GAP; // spacing paces the flow
                        tcnt_reg <= GAP_LAST;
                    end else begin
                        tcnt_reg <= tcnt_reg - 8'h01;
                    end
                end
                M_GAP: begin
                    if (!master_on) begin
                        mstate_reg <= M_IDLE;
                    end else if (tcnt_reg != 8'h00) begin
                        tcnt_reg <= tcnt_reg - 8'h01;
                    end else if (dmarq && busy && room_ok) begin
                        mstate_reg <= M_STB; // peripheral still requests
                        tcnt_reg <= STB_LAST;
                    end else begin
                        mstate_reg <= M_IDLE; // burst length set by peripheral
                    end
                end
                default: mstate_reg <= M_IDLE;
            endcase
        end
    end

    // ==========================================================
    // configuration page and transfer count, register read port
    always @(posedge SYS_CLK_I or negedge MRST_N_I) begin
        if (!MRST_N_I) begin
            cfg_reg <= `BMDMA_CFG_RESET;
            rem_reg <= {CNT_W{1'b0}};
            RDATA_O <= 16'h0000;
        end else if (RST_I) begin
            cfg_reg <= `BMDMA_CFG_RESET;
            rem_reg <= {CNT_W{1'b0}};
            RDATA_O <= 16'h0000;
        end else begin
            // software writes the shared configuration page
            if (WR_I && ADDR_I == `BMDMA_CFG_ADDR) begin
                cfg_reg <= WDATA_I;
            end
            // a new count starts a transfer, otherwise count units down
            if (WR_I && ADDR_I == `BMDMA_CNT_ADDR) begin
                rem_reg <= WDATA_I[CNT_W-1:0];
            end else if (xfer && busy) begin
                rem_reg <= rem_reg - one_cnt;
            end
            // read data one cycle after the strobe, zero when unmapped
            if (RD_I) begin
                case (ADDR_I)
                    `BMDMA_CFG_ADDR: RDATA_O <= cfg_reg;
                    `BMDMA_CNT_ADDR: RDATA_O <= rem_reg;
                    `BMDMA_STAT_ADDR: RDATA_O <= {9'h000, mstate_reg, sstate_reg,
                                                  lvl, busy};
                    default: RDATA_O <= 16'h0000;
                endcase
            end else begin
                RDATA_O <= 16'h0000;
            end
        end
    end

    // ==========================================================
    // fifo side: push inbound units, pop outbound units, hold output data
    always @(posedge SYS_CLK_I or negedge MRST_N_I) begin
        if (!MRST_N_I) begin
            FIFO_PUSH_O <= 1'b0;
            FIFO_POP_O <= 1'b0;
            FIFO_WDATA_O <= 16'h0000;
            dout_reg <= 16'h0000;
        end else if (RST_I) begin
            FIFO_PUSH_O <= 1'b0;
            FIFO_POP_O <= 1'b0;
            FIFO_WDATA_O <= 16'h0000;
            dout_reg <= 16'h0000;
        end else begin
            FIFO_PUSH_O <= xfer & busy & inbound;
            FIFO_POP_O <= xfer & busy & ~inbound;
            if (xfer && inbound) begin
                // narrow bus uses only the low byte lanes
                FIFO_WDATA_O <= wide ? DMA_DATA_I : {8'h00, DMA_DATA_I[7:0]};
            end
            // keep the fifo head on the bus until the unit is taken
            if (!bus_drive) begin
                dout_reg <= FIFO_RDATA_I;
            end
        end
    end

    // ==========================================================
    // pin outputs
    // master acknowledge: whole access in mode 0, strobe time in modes 1/2
    wire m_dmack = (mode == `BMDMA_MODE_STROBES) ? (mstate_reg != M_IDLE) :
                   (mstate_reg == M_STB);
    wire m_stb = mstate_reg == M_STB;
    // request pin: slave request or master ata acknowledge
    wire req_act = loaded & (master ? m_dmack : (sstate_reg == S_REQ));
    // master strobes: write strobe inbound (modes 0/1), read strobe outbound (mode 0)
    wire m_wr_act = master_on & m_stb & inbound & (mode != `BMDMA_MODE_ACK_BOTH);
    wire m_rd_act = master_on & m_stb & ~inbound & (mode == `BMDMA_MODE_STROBES);

    // outbound bus drive window
    assign bus_drive = ~inbound & busy &
                     (slave_on ? s_gate_lvl : (master_on & m_dmack));

    assign DMA_REQ_O = cfg_reg[`BMDMA_CFG_POL_REQ] ? req_act : ~req_act;
    assign DMA_WR_O = cfg_reg[`BMDMA_CFG_POL_WR] ? m_wr_act : ~m_wr_act;
    assign DMA_RD_O = cfg_reg[`BMDMA_CFG_POL_RD] ? m_rd_act : ~m_rd_act;
    assign DMA_WR_OE_O = master_on;
    assign DMA_RD_OE_O = master_on;
    assign DMA_DATA_O = dout_reg;
    assign DMA_DATA_OE_O = {{8{bus_drive & wide}}, {8{bus_drive}}};

endmodule // bmdma_port

// ---- testbench/bmdma_port_checker.sv ----
// bmdma_port_checker.sv: port assertions for the buffer-manager dma port.
// assumes binding to bmdma_port; config written only over the register port.
`timescale 1ns/10ps
`include "bmdma_regs.vh"

module bmdma_port_checker #(
    parameter CNT_W = 16,
    parameter LVL_W = 8
) (
    input wire SYS_CLK_I,
    input wire RST_I,
    input wire MRST_N_I,
    input wire [3:0] ADDR_I,
    input wire [15:0] WDATA_I,
    input wire WR_I,
    input wire DMA_REQ_O,
    input wire DMA_ACK_I,
    input wire DMA_WR_I,
    input wire DMA_RD_OE_O,
    input wire DMA_WR_OE_O,
    input wire [15:0] DMA_DATA_OE_O,
    input wire [LVL_W-1:0] FIFO_DATA_CNT_I,
    input wire [LVL_W-1:0] FIFO_ROOM_CNT_I,
    input wire FIFO_PUSH_O,
    input wire FIFO_POP_O,
    input wire [15:0] FIFO_WDATA_O
);
    // ====
    // shadow config and count
    reg [15:0] cfg_reg; // last config word written
    reg [CNT_W-1:0] cnt_reg; // units still owed
    wire valid = cfg_reg[`BMDMA_CFG_VALID];
    wire master = cfg_reg[`BMDMA_CFG_MASTER];
    wire slave = valid & ~master;
    wire inb = cfg_reg[`BMDMA_CFG_INBOUND];
    wire wide = cfg_reg[`BMDMA_CFG_WIDE];
    wire [1:0] mode = cfg_reg[`BMDMA_CFG_MODE_HI:`BMDMA_CFG_MODE_LO];
    wire req_act = (DMA_REQ_O == cfg_reg[`BMDMA_CFG_POL_REQ]);
    wire ack_act = (DMA_ACK_I == cfg_reg[`BMDMA_CFG_POL_ACK]);
    wire wr_act = (DMA_WR_I == cfg_reg[`BMDMA_CFG_POL_WR]);
    wire [LVL_W-1:0] avail = inb ? FIFO_ROOM_CNT_I : FIFO_DATA_CNT_I;

    // tracks writes and moved units
    always @(posedge SYS_CLK_I or negedge MRST_N_I) begin
        if (!MRST_N_I || RST_I) begin
            cfg_reg <= `BMDMA_CFG_RESET;
            cnt_reg <= {CNT_W{1'b0}};
        end else if (WR_I && ADDR_I == `BMDMA_CFG_ADDR) begin
            cfg_reg <= WDATA_I;
        end else if (WR_I && ADDR_I == `BMDMA_CNT_ADDR) begin
            cnt_reg <= WDATA_I[CNT_W-1:0];
        end else if ((FIFO_PUSH_O || FIFO_POP_O) && cnt_reg != {CNT_W{1'b0}}) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I || !MRST_N_I);

    // ====
    // assertions
    AST_NO_REQ_EMPTY: assert property (
        (slave && avail == 0) [*2] |-> !req_act) else $error("request with fifo empty");
    AST_IDLE_OUTPUTS: assert property (
        !valid |-> DMA_REQ_O == !cfg_reg[`BMDMA_CFG_POL_REQ] && !DMA_RD_OE_O
        && !DMA_WR_OE_O && DMA_DATA_OE_O == 16'h0000) else $error("pins active without config");
    AST_SLAVE_PINS_IN: assert property (
        slave |-> !DMA_RD_OE_O && !DMA_WR_OE_O) else $error("slave drives strobes");
    AST_MASTER_PINS_OUT: assert property (
        valid && master |-> DMA_RD_OE_O && DMA_WR_OE_O) else $error("master not driving strobes");
    AST_NARROW_LANES: assert property (
        !wide |-> DMA_DATA_OE_O[15:8] == 8'h00) else $error("narrow bus drives high byte");
    AST_NARROW_PUSH: assert property (
        FIFO_PUSH_O && !wide |-> FIFO_WDATA_O[15:8] == 8'h00) else $error("narrow push high byte");
    AST_MODE0_LATCH: assert property (
        slave && inb && mode == 2'h0 && $rose(wr_act) && cnt_reg != 0 |=> FIFO_PUSH_O)
        else $error("write strobe did not push");
    AST_MODE2_LATCH: assert property (
        slave && inb && mode == 2'h2 && $rose(ack_act) && cnt_reg != 0 |=> FIFO_PUSH_O)
        else $error("acknowledge did not push");
    AST_ACK_GATES: assert property (
        slave && !inb && wide && mode == 2'h1 && ack_act [*2] |-> DMA_DATA_OE_O == 16'hFFFF)
        else $error("acknowledge did not gate bus");
    AST_DMACK_ANSWER: assert property (
        valid && master && $rose(ack_act) && cnt_reg != 0 && avail != 0 |-> ##[1:3] req_act)
        else $error("no dma acknowledge to request");

    // main scenarios reached
    cover property (slave && req_act && FIFO_PUSH_O);
    cover property (slave && FIFO_POP_O);
    cover property (valid && master && FIFO_PUSH_O);
endmodule // bmdma_port_checker

bind bmdma_port bmdma_port_checker #(.CNT_W(CNT_W), .LVL_W(LVL_W)) CHK (.*);

// ---- testbench/bmdma_mgr_model.sv ----
// bmdma_mgr_model.sv: buffer manager answering the slave-mode request.
// assumes active-high pins; gap_i adds idle cycles per unit.
`timescale 1ns/10ps

module bmdma_mgr_model (
    input wire clk_i,
    input wire req_i,
    input wire inbound_i,
    input wire [3:0] gap_i,
    output reg ack_o,
    output reg wr_o,
    output reg rd_o,
    output reg [15:0] data_o,
    output reg [7:0] units_o
);
    reg [4:0] ph_reg; // phase inside one unit, 0 is idle

    initial begin
        ph_reg = 5'h00;
        ack_o = 1'b0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        data_o = 16'hA55A;
        units_o = 8'h00;
    end

    // ====
    // one unit: ack, strobe two cycles, release, idle gap
    always @(posedge clk_i) begin
        if (ph_reg == 5'h00) begin
            if (req_i) begin // answer the request
                ph_reg <= 5'h01;
                ack_o <= 1'b1;
                data_o <= 16'h1000 + {8'h00, units_o};
            end else begin
                data_o <= ~data_o; // released bus keeps moving
            end
        end else begin
            ph_reg <= (ph_reg >= 5'h04 + {1'b0, gap_i}) ? 5'h00 : ph_reg + 5'h01;
            if (ph_reg == 5'h01) begin // manager drives the strobe
                wr_o <= inbound_i;
                rd_o <= ~inbound_i;
            end
            if (ph_reg == 5'h03) begin // unit over, strobes released
                ack_o <= 1'b0;
                wr_o <= 1'b0;
                rd_o <= 1'b0;
                units_o <= units_o + 8'h01;
            end
            if (ph_reg >= 5'h03) data_o <= ~data_o;
        end
    end
endmodule // bmdma_mgr_model

// ---- testbench/buffer_manager_dma_port_tb.sv ----
// buffer_manager_dma_port_tb.sv: self-checking bench for the dma port.
// assumes the manager model and fifo levels held by the bench.
`timescale 1ns/10ps
`include "bmdma_regs.vh"

module buffer_manager_dma_port_tb;
    reg SYS_CLK_I, RST_I, MRST_N_I, WR_I, RD_I, mst_sel, dmarq, out_chk, inbound, wide_q, gate_q;
    reg [3:0] ADDR_I, gap;
    reg [1:0] cur_mode;
    reg [15:0] WDATA_I, FIFO_RDATA_I, mst_data, exp_w, v;
    reg [7:0] FIFO_DATA_CNT_I, FIFO_ROOM_CNT_I;
    wire [15:0] RDATA_O, DMA_DATA_O, DMA_DATA_OE_O, FIFO_WDATA_O, mdl_data, DMA_DATA_I;
    wire DMA_REQ_O, DMA_RD_O, DMA_RD_OE_O, DMA_WR_O, DMA_WR_OE_O, FIFO_POP_O, FIFO_PUSH_O;
    wire mdl_ack, mdl_wr, mdl_rd;
    wire [7:0] mdl_units;
    integer error_cnt, samples_checked, pushes, pops, exp_idx, d, m;

    // ====
    // pin levels from every driver
    wire DMA_ACK_I = mst_sel ? dmarq : mdl_ack;
    wire DMA_WR_I = DMA_WR_OE_O ? DMA_WR_O : mdl_wr;
    wire DMA_RD_I = DMA_RD_OE_O ? DMA_RD_O : mdl_rd;
    assign DMA_DATA_I = (DMA_DATA_OE_O & DMA_DATA_O) | (~DMA_DATA_OE_O & (mst_sel ? mst_data : mdl_data));
    wire gate = (cur_mode == 2'h0) ? DMA_RD_I : DMA_ACK_I;

    bmdma_port DUT (.*);

    bmdma_mgr_model MGR (
        .clk_i(SYS_CLK_I),
        .req_i(DMA_REQ_O & ~mst_sel),
        .inbound_i(inbound),
        .gap_i(gap),
        .ack_o(mdl_ack),
        .wr_o(mdl_wr),
        .rd_o(mdl_rd),
        .data_o(mdl_data),
        .units_o(mdl_units)
    );

    initial begin
        SYS_CLK_I = 1'b0;
        forever #25 SYS_CLK_I = ~SYS_CLK_I;
    end

    // ====
    // shared tasks
    task check16(input [8*16-1:0] name, input [15:0] exp, input [15:0] got); begin
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            $display("BAD %0s expected %h seen %h", name, exp, got);
            error_cnt = error_cnt + 1;
        end
    end endtask

    task wr_reg(input [3:0] a, input [15:0] dat); begin
        @(posedge SYS_CLK_I);
        ADDR_I <= a;
        WDATA_I <= dat;
        WR_I <= 1'b1;
        @(posedge SYS_CLK_I);
        WR_I <= 1'b0;
    end endtask

    task rd_reg(input [3:0] a, output [15:0] dat); begin
        @(posedge SYS_CLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge SYS_CLK_I);
        RD_I <= 1'b0;
        @(negedge SYS_CLK_I);
        dat = RDATA_O;
    end endtask

    task start(input [15:0] cfg, input [15:0] n); begin
        exp_idx = mdl_units;
        pushes = 0;
        pops = 0;
        inbound = cfg[10];
        wide_q = cfg[0];
        cur_mode = cfg[9:8];
        out_chk = ~cfg[10] & ~cfg[5];
        wr_reg(`BMDMA_CFG_ADDR, cfg);
        wr_reg(`BMDMA_CNT_ADDR, n);
    end endtask

    task finish_xfer(input [15:0] n); integer k; begin
        v = 16'hFFFF;
        for (k = 0; k < 300 && v !== 16'h0000; k = k + 1) rd_reg(`BMDMA_CNT_ADDR, v);
        repeat (8) @(posedge SYS_CLK_I);
        check16("count_left", 16'h0000, v);
        check16("units", n, inbound ? pushes[15:0] : pops[15:0]);
    end endtask

    task print_verdict; begin
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    end endtask

    // fifo side: pushed data and bus gating
    always @(posedge SYS_CLK_I) begin
        exp_w = mst_sel ? mst_data : 16'h1000 + exp_idx[15:0];
        gate_q <= gate;
        if (FIFO_PUSH_O === 1'b1) begin
            check16("push_data", wide_q ? exp_w : {8'h00, exp_w[7:0]}, FIFO_WDATA_O);
            pushes = pushes + 1;
            exp_idx = exp_idx + 1;
        end
        if (FIFO_POP_O === 1'b1) pops = pops + 1;
        if (out_chk && gate && gate_q) begin
            check16("bus_oe", 16'hFFFF, DMA_DATA_OE_O);
            check16("bus_data", FIFO_RDATA_I, DMA_DATA_O);
        end
    end

    // hang guard
    initial begin
        #(40000 * 50);
        error_cnt = error_cnt + 1;
        print_verdict;
    end

    // ====
    // test sequence
    initial begin
        RST_I = 1'b1; MRST_N_I = 1'b1; WR_I = 1'b0; RD_I = 1'b0; ADDR_I = 4'h0;
        WDATA_I = 16'h0000; FIFO_DATA_CNT_I = 8'h08; FIFO_ROOM_CNT_I = 8'h00;
        FIFO_RDATA_I = 16'h7E81; mst_data = 16'h3C5A; mst_sel = 1'b0; dmarq = 1'b0;
        gap = 4'h0; out_chk = 1'b0; inbound = 1'b1; wide_q = 1'b1; cur_mode = 2'h0; gate_q = 1'b0;
        error_cnt = 0; samples_checked = 0; pushes = 0; pops = 0; exp_idx = 0;
        repeat (5) @(posedge SYS_CLK_I);
        RST_I <= 1'b0;
        @(negedge SYS_CLK_I);
        check16("req_idle", 16'h0001, {15'h0, DMA_REQ_O});
        check16("data_oe_idle", 16'h0000, DMA_DATA_OE_O);
        wr_reg(`BMDMA_CFG_ADDR, 16'h8400);
        @(negedge SYS_CLK_I);
        check16("req_low_true", 16'h0001, {15'h0, DMA_REQ_O});
        wr_reg(`BMDMA_CFG_ADDR, 16'h8402);
        FIFO_ROOM_CNT_I <= 8'h08;
        rd_reg(`BMDMA_CFG_ADDR, v);
        check16("cfg_read", 16'h8402, v);
        check16("req_high_true", 16'h0000, {15'h0, DMA_REQ_O});
        rd_reg(4'hF, v);
        check16("unmapped", 16'h0000, v);
        // each strobe mode both ways, held request
        for (d = 0; d < 2; d = d + 1) for (m = 0; m < 3; m = m + 1) begin
            gap = d ? 4'h0 : 4'h3;
            start({5'b10000, d[0], m[1:0], 8'h1F}, 16'h0004);
            finish_xfer(16'h0004);
        end
        // each burst, narrow bus, ack latching
        for (m = 0; m < 4; m = m + 1) begin
            start({8'h86, m[1:0], 6'h1E}, 16'h0008);
            finish_xfer(16'h0008);
        end
        // four-unit burst must wait for room
        FIFO_ROOM_CNT_I <= 8'h03;
        start(16'h86DE, 16'h0004);
        repeat (20) @(posedge SYS_CLK_I);
        @(negedge SYS_CLK_I);
        check16("req_wait", 16'h0000, {15'h0, DMA_REQ_O});
        check16("no_push", 16'h0000, pushes[15:0]);
        @(posedge SYS_CLK_I);
        FIFO_ROOM_CNT_I <= 8'h08;
        finish_xfer(16'h0004);
        // master, peripheral holds request
        mst_sel <= 1'b1;
        start(16'h843F, 16'h0003);
        dmarq <= 1'b1;
        finish_xfer(16'h0003);
        dmarq <= 1'b0;
        mst_sel <= 1'b0;
        // async master reset, no clock needed
        wr_reg(`BMDMA_CFG_ADDR, 16'h8402);
        MRST_N_I <= 1'b0;
        #5;
        check16("req_after_mrst", 16'h0001, {15'h0, DMA_REQ_O});
        @(posedge SYS_CLK_I);
        MRST_N_I <= 1'b1;
        rd_reg(`BMDMA_CFG_ADDR, v);
        check16("cfg_after_mrst", 16'h0000, v);
        print_verdict;
    end
endmodule // buffer_manager_dma_port_tb
